// ==== inc/ucf_pkg.sv ====
// constants, register map and state types for the serial channel
// assumes a 32-bit register bus and byte-wide character data
package ucf_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int FIFO_DEPTH_DEF = 64;
  localparam int TX_W = 8;
  localparam int RX_W = 11;
  // register byte addresses
  localparam logic [7:0] OFF_HOLDING = 8'h00;
  localparam logic [7:0] OFF_INT_ENABLE = 8'h04;
  localparam logic [7:0] OFF_INT_STATUS = 8'h08;
  localparam logic [7:0] OFF_FIFO_CTRL = 8'h0c;
  localparam logic [7:0] OFF_LINE_CTRL = 8'h10;
  localparam logic [7:0] OFF_MODEM_CTRL = 8'h14;
  localparam logic [7:0] OFF_LINE_STATUS = 8'h18;
  localparam logic [7:0] OFF_ENH_FEATURE = 8'h1c;
  localparam logic [7:0] OFF_EXT_MODE = 8'h20;
  localparam logic [7:0] OFF_BAUD_DIV = 8'h24;
  // field positions
  localparam int FCR_EN = 0;
  localparam int FCR_RX_FLUSH = 1;
  localparam int FCR_TX_FLUSH = 2;
  localparam int FCR_TX_TRIG = 4;
  localparam int FCR_RX_TRIG = 6;
  localparam logic [7:0] FCR_KEEP_MASK = 8'hf9;
  localparam int LCR_STOP2 = 2;
  localparam int LCR_PAR_EN = 3;
  localparam int LCR_PAR_EVEN = 4;
  localparam int MCR_RTS = 1;
  localparam int EFR_ENH = 4;
  localparam int EFR_AUTO_RTS = 6;
  localparam int EFR_AUTO_CTS = 7;
  localparam int EMR_OS16 = 7;
  localparam int IER_RX = 0;
  localparam int IER_TX = 1;
  localparam int IER_RTS = 6;
  localparam int IER_CTS = 7;
  // reset values
  localparam logic [7:0] LCR_RST = 8'h03;
  localparam logic [7:0] EMR_RST = 8'h80;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0000;
  // oversampling counts, last tick of a bit and mid-bit tick
  localparam logic [3:0] OS_LAST_16 = 4'hf;
  localparam logic [3:0] OS_LAST_8 = 4'h7;
  localparam logic [3:0] OS_MID_16 = 4'h7;
  localparam logic [3:0] OS_MID_8 = 4'h3;
  localparam logic [3:0] WORD_BASE = 4'h5;
  localparam logic [2:0] LAST_BIT_BASE = 3'h4;
  localparam int TMO_WORDS = 4;
  localparam int TMO_EXTRA_BITS = 12;
  // trigger tables, entry 0 lowest
  localparam logic [3:0][7:0] RX_TRIG = {8'h3c, 8'h38, 8'h10, 8'h08};
  localparam logic [3:0][7:0] TX_TRIG = {8'h38, 8'h20, 8'h10, 8'h08};
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} ucf_tx_state_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} ucf_rx_state_t;
endpackage

// ==== inc/ucf_fifo_if.sv ====
// push/pop port pair between the channel logic and one fifo store
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface ucf_fifo_if #(parameter int W = 8, parameter int CW = 7);
  logic push;
  logic pop;
  logic flush;
  logic [W-1:0] wdata;
  logic [W-1:0] rdata;
  logic [CW-1:0] count;
  logic full;
  logic empty;
  modport user (output push, output pop, output flush, output wdata,
                input rdata, input count, input full, input empty);
  modport store (input push, input pop, input flush, input wdata,
                 output rdata, output count, output full, output empty);
endinterface

// ==== hdl/ucf_fifo.sv ====
// flip-flop fifo with fill count, head shown without a pop
// assumes push is dropped when full and pop ignored when empty
`timescale 1ns/1ns
module ucf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 64
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  ucf_fifo_if.store port
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic do_push;
  logic do_pop;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_chk
      $error("fifo depth must be a power of two of at least two");
    end
  endgenerate

  // gated strobes keep the count honest at both limits
  assign do_push = ce && port.push && !port.full;
  assign do_pop = ce && port.pop && !port.empty;
  assign port.rdata = mem_q[rd_ptr_q];
  assign port.count = count_q;
  assign port.full = (count_q == (AW + 1)'(DEPTH));
  assign port.empty = (count_q == '0);

  // storage, data needs no reset
  always_ff @(posedge ref_clk)
  begin
    if (do_push)
      mem_q[wr_ptr_q] <= port.wdata;
  end

  // pointers and fill; flush wins over traffic
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else if (ce && port.flush)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (do_push)
        wr_ptr_q <= wr_ptr_q + 1'b1;
      if (do_pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      if (do_push && !do_pop)
        count_q <= count_q + 1'b1;
      else if (do_pop && !do_push)
        count_q <= count_q - 1'b1;
    end
  end
endmodule

// ==== hdl/ucf_uart.sv ====
// one serial channel: tx/rx fifos, framing, timeout, rts/cts flow control
// assumes axi4-lite master on ref_clk and line inputs already synchronous
// Notes on behaviour
// - transmit bits last sixteen or eight oversampling ticks
// - frame is start, data lsb first, optional parity, stop bits
// - holding writes go into the 64-byte tx fifo when fifos enabled
// - without fifo, holding-empty sets when byte moves to shifter
// - transmitter-empty sets only with shifter idle and tx fifo empty
// - with fifo, holding-empty set whenever tx fifo is empty
// - tx empty interrupt needs enable bit 1; fifo mode below trigger
// - falling edge starts count; mid start bit must still be low
// - data and stop bits sampled at centre with same count
// - rx fifo 64 by 11 bits; head tags shown in status bits 2-4
// - reading rx holding pops fifo and refreshes error bits at once
// - rx ready interrupt per character or at fifo trigger
// - timeout after four words plus twelve bits with data waiting
// - auto rts enabled by feature bit 6, started by modem bit 1
// - rts rise sets flow status bit when enabled with feature bit 4
// - auto rts high at upper limit, low at lower, rx continues
// - hysteresis limits are neighbouring trigger table entries, full or empty fifo at the ends
// - auto cts by feature bit 7; cts rise sets flow status bit
// - cts high halts tx after current stop bit; resumes when low
// - oversampling select 1 gives sixteen, 0 gives eight ticks
`timescale 1ns/1ns
module ucf_uart
  import ucf_pkg::*;
#(
  parameter int FIFO_DEPTH = ucf_pkg::FIFO_DEPTH_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [ucf_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ucf_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ucf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [ucf_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic txd,
  input wire logic rxd,
  output logic rts_n,
  input wire logic cts_n,
  output logic irq
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  generate
    if (FIFO_DEPTH < 64)
    begin : g_chk
      $error("fifo depth must cover the largest trigger level");
    end
  endgenerate

  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_full_q, w_full_q;
  logic [1:0] bresp_q, rresp_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q, rdata_q, rd_data;
  logic [3:0] wstrb_q;
  logic wr_fire, wr_ok, rd_fire, rd_ok;
  logic [7:0] ier_q, fcr_q, lcr_q, mcr_q, efr_q, emr_q;
  logic [15:0] div_q, div_cnt_q;
  logic os_tick_q;
  ucf_tx_state_t tx_state_q;
  ucf_rx_state_t rx_state_q;
  logic [3:0] tx_os_q, rx_os_q, os_last, os_mid, nbits;
  logic [2:0] tx_bit_q, rx_bit_q, last_bit;
  logic [7:0] tx_shift_q, rx_shift_q, wmask, lsr_vec, isr_vec;
  logic tx_q, tx_start, cts_hold;
  logic rx_prev_q, rx_par_q, rx_push_q, rx_done, rx_pe, rx_brk;
  logic [RX_W-1:0] rx_word_q;
  logic ovr_q, flow_q, rts_n_q, rts_prev_q, cts_prev_q, irq_q;
  logic [10:0] tmo_cnt_q, tmo_limit;
  logic [6:0] tmo_bits;
  logic tmo_q, fifo_en, tx_full_eff, rx_full_eff;
  logic tx_int, rx_int, tmo_int, rts_rise, cts_rise, thre, temt;
  logic [CW-1:0] rx_trig, tx_trig, hyst_hi, hyst_lo;
  logic [1:0] rx_sel;

  ucf_fifo_if #(.W(TX_W), .CW(CW)) tx_if ();
  ucf_fifo_if #(.W(RX_W), .CW(CW)) rx_if ();

  ucf_fifo #(.WIDTH(TX_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .port(tx_if.store)
  );

  ucf_fifo #(.WIDTH(RX_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .port(rx_if.store)
  );

  // mode decode shared by both directions
  assign fifo_en = fcr_q[FCR_EN];
  assign os_last = emr_q[EMR_OS16] ? OS_LAST_16 : OS_LAST_8;
  assign os_mid = emr_q[EMR_OS16] ? OS_MID_16 : OS_MID_8;
  assign nbits = WORD_BASE + {2'h0, lcr_q[1:0]};
  assign last_bit = LAST_BIT_BASE + {1'b0, lcr_q[1:0]};
  assign wmask = 8'hff >> (4'h8 - nbits);
  // non-fifo mode behaves as a one-deep holding register
  assign tx_full_eff = fifo_en ? tx_if.full : !tx_if.empty;
  assign rx_full_eff = fifo_en ? rx_if.full : !rx_if.empty;
  assign rx_sel = fcr_q[FCR_RX_TRIG +: 2];
  assign rx_trig = CW'(RX_TRIG[rx_sel]);
  assign tx_trig = CW'(TX_TRIG[fcr_q[FCR_TX_TRIG +: 2]]);
  // neighbouring table entries, top limit is a full fifo and bottom limit an empty one
  assign hyst_hi = (rx_sel == 2'h3) ? CW'(FIFO_DEPTH) : CW'(RX_TRIG[rx_sel + 2'h1]);
  assign hyst_lo = (rx_sel == 2'h0) ? '0 : CW'(RX_TRIG[rx_sel - 2'h1]);

  // bus strobes
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
  assign rd_fire = s_axi_arvalid && arready_q;
  assign tx_if.push = wr_fire && awaddr_q == OFF_HOLDING && wstrb_q[0] && !tx_full_eff;
  assign tx_if.wdata = wdata_q[7:0];
  assign tx_if.flush = wr_fire && awaddr_q == OFF_FIFO_CTRL && wstrb_q[0] && wdata_q[FCR_TX_FLUSH];
  assign rx_if.flush = wr_fire && awaddr_q == OFF_FIFO_CTRL && wstrb_q[0] && wdata_q[FCR_RX_FLUSH];
  assign rx_if.pop = rd_fire && s_axi_araddr == OFF_HOLDING;
  assign rx_if.push = rx_push_q;
  assign rx_if.wdata = rx_word_q;

  // status views
  assign thre = tx_if.empty;
  assign temt = tx_if.empty && tx_state_q == TX_IDLE;
  assign tx_int = ier_q[IER_TX] && (fifo_en ? tx_if.count < tx_trig : tx_if.empty);
  assign rx_int = ier_q[IER_RX] && (fifo_en ? rx_if.count >= rx_trig : !rx_if.empty);
  assign tmo_int = ier_q[IER_RX] && tmo_q;
  // head tags hidden while the fifo is empty
  assign lsr_vec = {1'b0, temt, thre, rx_if.rdata[10:8] & {3{!rx_if.empty}}, ovr_q,
                    !rx_if.empty};
  assign isr_vec = {2'h0, flow_q, 1'b0, tmo_int, rx_int, tx_int,
                    tx_int | rx_int | tmo_int | flow_q};

  // write side decode answer
  always_comb
  begin
    case (awaddr_q)
      OFF_HOLDING, OFF_INT_ENABLE, OFF_INT_STATUS, OFF_FIFO_CTRL, OFF_LINE_CTRL,
      OFF_MODEM_CTRL, OFF_LINE_STATUS, OFF_ENH_FEATURE, OFF_EXT_MODE, OFF_BAUD_DIV:
        wr_ok = 1'b1;
      default:
        wr_ok = 1'b0;
    endcase
  end

  // read mux, upper bits read as zero
  always_comb
  begin
    rd_data = '0;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      OFF_HOLDING: rd_data[7:0] = rx_if.empty ? 8'h00 : rx_if.rdata[7:0];
      OFF_INT_ENABLE: rd_data[7:0] = ier_q;
      OFF_INT_STATUS: rd_data[7:0] = isr_vec;
      OFF_FIFO_CTRL: rd_data[7:0] = fcr_q;
      OFF_LINE_CTRL: rd_data[7:0] = lcr_q;
      OFF_MODEM_CTRL: rd_data[7:0] = mcr_q;
      OFF_LINE_STATUS: rd_data[7:0] = lsr_vec;
      OFF_ENH_FEATURE: rd_data[7:0] = efr_q;
      OFF_EXT_MODE: rd_data[7:0] = emr_q;
      OFF_BAUD_DIV: rd_data[15:0] = div_q;
      default: rd_ok = 1'b0;
    endcase
  end

  // axi write channels; address and data taken in either order
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= AXI_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && awready_q)
      begin
        awaddr_q <= s_axi_awaddr;
        awready_q <= 1'b0;
        aw_full_q <= 1'b1;
      end
      if (s_axi_wvalid && wready_q)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        wready_q <= 1'b0;
        w_full_q <= 1'b1;
      end
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? AXI_OKAY : AXI_SLVERR;
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // axi read channels, answer one cycle after the address is taken
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= AXI_OKAY;
    end
    else if (ce)
    begin
      if (rd_fire)
      begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_data;
        rresp_q <= rd_ok ? AXI_OKAY : AXI_SLVERR;
      end
      if (rvalid_q && s_axi_rready)
      begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // configuration registers; flush bits never stick
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ier_q <= CFG_RST;
      fcr_q <= CFG_RST;
      lcr_q <= LCR_RST;
      mcr_q <= CFG_RST;
      efr_q <= CFG_RST;
      emr_q <= EMR_RST;
      div_q <= DIV_RST;
    end
    else if (ce && wr_fire)
    begin
      if (wstrb_q[0])
      begin
        case (awaddr_q)
          OFF_INT_ENABLE: ier_q <= wdata_q[7:0];
          OFF_FIFO_CTRL: fcr_q <= wdata_q[7:0] & FCR_KEEP_MASK;
          OFF_LINE_CTRL: lcr_q <= wdata_q[7:0];
          OFF_MODEM_CTRL: mcr_q <= wdata_q[7:0];
          OFF_ENH_FEATURE: efr_q <= wdata_q[7:0];
          OFF_EXT_MODE: emr_q <= wdata_q[7:0];
          OFF_BAUD_DIV: div_q[7:0] <= wdata_q[7:0];
          default: ier_q <= ier_q;
        endcase
      end
      if (wstrb_q[1] && awaddr_q == OFF_BAUD_DIV)
        div_q[15:8] <= wdata_q[15:8];
    end
  end

  // oversampling tick every div+1 clocks, stands in for the baud generator
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_cnt_q <= '0;
      os_tick_q <= 1'b0;
    end
    else if (ce)
    begin
      os_tick_q <= (div_cnt_q == div_q);
      div_cnt_q <= (div_cnt_q == div_q) ? '0 : div_cnt_q + 1'b1;
    end
  end

  // a character is only started between frames, so cts never cuts one
  assign cts_hold = efr_q[EFR_AUTO_CTS] && cts_n;
  assign tx_start = os_tick_q && tx_state_q == TX_IDLE && !tx_if.empty && !cts_hold;
  assign tx_if.pop = tx_start;

  // transmitter, one step per oversampling tick
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state_q <= TX_IDLE;
      tx_os_q <= '0;
      tx_bit_q <= '0;
      tx_shift_q <= '0;
      tx_q <= 1'b1;
    end
    else if (ce && os_tick_q)
    begin
      tx_os_q <= (tx_os_q == os_last) ? 4'h0 : tx_os_q + 4'h1;
      case (tx_state_q)
        TX_IDLE:
        begin
          tx_os_q <= '0;
          if (tx_start)
          begin
            tx_state_q <= TX_START;
            tx_shift_q <= tx_if.rdata & wmask;
            tx_bit_q <= '0;
            tx_q <= 1'b0;
          end
        end
        TX_START:
          if (tx_os_q == os_last)
          begin
            tx_state_q <= TX_DATA;
            tx_q <= tx_shift_q[0];
          end
        TX_DATA:
          if (tx_os_q == os_last)
          begin
            if (tx_bit_q == last_bit)
            begin
              tx_state_q <= lcr_q[LCR_PAR_EN] ? TX_PARITY : TX_STOP;
              tx_q <= lcr_q[LCR_PAR_EN] ? (^tx_shift_q ^ ~lcr_q[LCR_PAR_EVEN]) : 1'b1;
              tx_bit_q <= '0;
            end
            else
            begin
              // byte kept whole so the parity bit covers every data bit
              tx_q <= tx_shift_q[tx_bit_q + 3'h1];
              tx_bit_q <= tx_bit_q + 3'h1;
            end
          end
        TX_PARITY:
          if (tx_os_q == os_last)
          begin
            tx_state_q <= TX_STOP;
            tx_q <= 1'b1;
          end
        TX_STOP:
          if (tx_os_q == os_last)
          begin
            if (lcr_q[LCR_STOP2] && tx_bit_q == 3'h0)
              tx_bit_q <= 3'h1;
            else
              tx_state_q <= TX_IDLE;
          end
        default:
          tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // receive checks on the stop sample
  assign rx_done = os_tick_q && rx_state_q == RX_STOP && rx_os_q == os_last;
  assign rx_pe = lcr_q[LCR_PAR_EN] && (rx_par_q != (^rx_shift_q ^ ~lcr_q[LCR_PAR_EVEN]));
  assign rx_brk = rx_shift_q == 8'h00 && !rx_par_q && !rxd;

  // receiver, counting from the falling edge of the start bit
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state_q <= RX_IDLE;
      rx_prev_q <= 1'b1;
      rx_os_q <= '0;
      rx_bit_q <= '0;
      rx_shift_q <= '0;
      rx_par_q <= 1'b0;
      rx_push_q <= 1'b0;
      rx_word_q <= '0;
    end
    else if (ce)
    begin
      rx_push_q <= rx_done && !rx_full_eff;
      if (rx_done)
        rx_word_q <= {rx_brk, !rxd, rx_pe, rx_shift_q};
      if (os_tick_q)
      begin
        rx_prev_q <= rxd;
        rx_os_q <= (rx_os_q == os_last) ? 4'h0 : rx_os_q + 4'h1;
        case (rx_state_q)
          RX_IDLE:
          begin
            rx_os_q <= '0;
            if (rx_prev_q && !rxd)
              rx_state_q <= RX_START;
          end
          RX_START:
            if (rx_os_q == os_mid)
            begin
              rx_os_q <= '0;
              rx_bit_q <= '0;
              rx_shift_q <= '0;
              rx_par_q <= 1'b0;
              rx_state_q <= rxd ? RX_IDLE : RX_DATA;
            end
          RX_DATA:
            if (rx_os_q == os_last)
            begin
              rx_shift_q[rx_bit_q] <= rxd;
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == last_bit)
                rx_state_q <= lcr_q[LCR_PAR_EN] ? RX_PARITY : RX_STOP;
            end
          RX_PARITY:
            if (rx_os_q == os_last)
            begin
              rx_par_q <= rxd;
              rx_state_q <= RX_STOP;
            end
          RX_STOP:
            if (rx_os_q == os_last)
              rx_state_q <= RX_IDLE;
          default:
            rx_state_q <= RX_IDLE;
        endcase
      end
    end
  end

  // overrun is sticky; a new overrun beats the clearing status read
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ovr_q <= 1'b0;
    else if (ce)
    begin
      if (rx_done && rx_full_eff)
        ovr_q <= 1'b1;
      else if (rd_fire && s_axi_araddr == OFF_LINE_STATUS)
        ovr_q <= 1'b0;
    end
  end

  // idle-line timeout, restarted by any character in or out
  assign tmo_bits = 7'(TMO_WORDS * int'(nbits) + TMO_EXTRA_BITS);
  assign tmo_limit = emr_q[EMR_OS16] ? {tmo_bits, 4'h0} : {1'b0, tmo_bits, 3'h0};
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tmo_cnt_q <= '0;
      tmo_q <= 1'b0;
    end
    else if (ce)
    begin
      if (rx_push_q || rx_if.pop || rx_if.empty || rx_state_q != RX_IDLE)
      begin
        tmo_cnt_q <= '0;
        tmo_q <= 1'b0;
      end
      else if (os_tick_q && !tmo_q)
      begin
        tmo_cnt_q <= tmo_cnt_q + 11'h001;
        if (tmo_cnt_q >= tmo_limit - 11'h001)
          tmo_q <= 1'b1;
      end
    end
  end

  // rts with hysteresis; the receiver keeps filling past the upper limit
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rts_n_q <= 1'b1;
    else if (ce)
    begin
      if (!mcr_q[MCR_RTS])
        rts_n_q <= 1'b1;
      else if (!efr_q[EFR_AUTO_RTS])
        rts_n_q <= 1'b0;
      else if (rx_if.count >= hyst_hi)
        rts_n_q <= 1'b1;
      else if (rx_if.count <= hyst_lo)
        rts_n_q <= 1'b0;
    end
  end

  // flow events: sticky status, cleared by reading status, set wins
  assign rts_rise = rts_n_q && !rts_prev_q && ier_q[IER_RTS] && efr_q[EFR_ENH];
  assign cts_rise = cts_n && !cts_prev_q && ier_q[IER_CTS] && efr_q[EFR_ENH];
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rts_prev_q <= 1'b1;
      cts_prev_q <= 1'b1;
      flow_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else if (ce)
    begin
      rts_prev_q <= rts_n_q;
      cts_prev_q <= cts_n;
      if (rts_rise || cts_rise)
        flow_q <= 1'b1;
      else if (rd_fire && s_axi_araddr == OFF_INT_STATUS)
        flow_q <= 1'b0;
      irq_q <= tx_int | rx_int | tmo_int | flow_q;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign txd = tx_q;
  assign rts_n = rts_n_q;
  assign irq = irq_q;
endmodule

// ==== bench/ucf_uart_monitor.sv ====
// checker on the channel's bus and serial pins
// assumes baud_div 0, one oversampling tick per clock
`timescale 1ns/1ns
module ucf_uart_monitor
  import ucf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ucf_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp,
  input wire logic txd
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
  b_delay_a: assert property (wr_take |-> ##2 s_axi_bvalid) else $error("write answer late");
  aw_block_a: assert property (wr_take |=> !s_axi_awready) else $error("second write taken");
  b_wait_a: assert property (s_axi_bvalid |-> !s_axi_wready) else $error("write data early");
  r_delay_a: assert property (rd_take |=> s_axi_rvalid) else $error("read answer late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
  r_err_a: assert property (rd_take ##0 s_axi_araddr > OFF_BAUD_DIV |=> s_axi_rresp == AXI_SLVERR)
    else $error("unmapped read not refused");
  start_len_a: assert property ($fell(txd) |-> !txd [*8])
    else $error("start bit short");
  bit_len_a: assert property ($rose(txd) |-> txd [*8])
    else $error("high bit short");
endmodule
bind ucf_uart ucf_uart_monitor mon (.*);

// ==== bench/ucf_rem.sv ====
// remote port model, sends 8n1 frames on rxd
// assumes 16 clocks a bit at the device (16x, baud_div 0)
`timescale 1ns/1ns
module ucf_rem (
  input wire logic ref_clk,
  input wire logic rts_n,
  output logic rxd
);
  logic [9:0] f;
  initial rxd = 1'b1;
  // holds off while rts is high, never cuts a frame short
  task send(input logic [7:0] d);
    f = {1'b1, d, 1'b0};
    while (rts_n) @(posedge ref_clk);
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i];
      repeat (16) @(posedge ref_clk);
    end
  endtask
  // low pulse shorter than half a bit
  task glitch();
    rxd <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rxd <= 1'b1;
    repeat (40) @(posedge ref_clk);
  endtask
endmodule

// ==== bench/ucf_uart_bench.sv ====
// bench: axi tasks, tx frame decoder, remote port on rxd
// assumes 16x sampling and baud_div 0 from reset
`timescale 1ns/1ns
module ucf_uart_bench;
  import ucf_pkg::*;
  logic ref_clk, rst_n, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, irq;
  logic s_axi_rready, txd, rxd, rts_n, cts_n, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, bq[$];
  logic [3:0] s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr, x, tq[$];
  logic [8:0] f;
  logic [31:0] s_axi_wdata, s_axi_rdata, rq[$], mq[$];
  int num_errors, n_compared;
  ucf_uart dut (.*);
  ucf_rem rem (.*);
  // 100 mhz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard, the run needs under 2000 cycles
  initial
  begin
    #200000;
    num_errors++;
    end_sim();
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_sim();
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // aw and w offered together, each released once taken; bready held high
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e = AXI_OKAY);
    logic ad, dd;
    bq.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    ad = 1'b0;
    dd = 1'b0;
    while (!(ad && dd))
    begin
      @(posedge ref_clk);
      ad = ad || s_axi_awready;
      dd = dd || s_axi_wready;
      if (ad)
        s_axi_awvalid <= 1'b0;
      if (dd)
        s_axi_wvalid <= 1'b0;
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
  endtask
  // notes the masked expectation, the watcher compares
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    rq.push_back(e);
    mq.push_back(m);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
  endtask
  // read watcher
  always @(posedge ref_clk)
    if (s_axi_rvalid && s_axi_rready) chk("rdata", s_axi_rdata & mq.pop_front(), rq.pop_front());
  // write answer watcher
  always @(posedge ref_clk)
    if (s_axi_bvalid && s_axi_bready) chk("bresp", 32'(s_axi_bresp), 32'(bq.pop_front()));
  // samples tx frames at bit centres
  initial
    forever
    begin
      @(negedge txd);
      repeat (8) @(posedge ref_clk);
      repeat (9)
      begin
        repeat (16) @(posedge ref_clk);
        f = {txd, f[8:1]};
      end
      chk("txd", {23'h0, f}, {23'h0, 1'b1, tq.pop_front()});
    end
  initial
  begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, cts_n} = '0;
    {ce, s_axi_bready, s_axi_rready, s_axi_wstrb} = '1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    void'($urandom(32'hf08e));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    wr(OFF_FIFO_CTRL, 32'h1);
    chk("rts_n", 32'(rts_n), 32'h1);
    wr(OFF_MODEM_CTRL, 32'h2);
    rd(OFF_LINE_STATUS, 32'h60);
    chk("rts_n", 32'(rts_n), 32'h0);
    rem.glitch();
    rd(OFF_LINE_STATUS, 32'h60);
    x = 8'($urandom);
    rem.send(x);
    wr(OFF_INT_ENABLE, 32'h1);
    repeat (600) @(posedge ref_clk);
    chk("irq", 32'(irq), 32'h0);
    rd(OFF_INT_STATUS, 32'h0, 32'hc);
    repeat (200) @(posedge ref_clk);
    rd(OFF_INT_STATUS, 32'h8, 32'hc);
    chk("irq", 32'(irq), 32'h1);
    rd(OFF_LINE_STATUS, 32'h61);
    rd(OFF_HOLDING, {24'h0, x});
    rd(OFF_LINE_STATUS, 32'h60);
    rd(8'h40, 32'h0);
    wr(8'h40, 32'h0, AXI_SLVERR);
    wr(OFF_ENH_FEATURE, 32'h80);
    cts_n <= 1'b1;
    repeat (2)
    begin
      x = 8'($urandom);
      tq.push_back(x);
      wr(OFF_HOLDING, {24'h0, x});
    end
    repeat (300) @(posedge ref_clk);
    chk("held", 32'(tq.size()), 32'h2);
    cts_n <= 1'b0;
    repeat (500) @(posedge ref_clk);
    chk("sent", 32'(tq.size()), 32'h0);
    end_sim();
  end
endmodule
